//--- hw/crcu_regs.vh
`ifndef CRCU_REGS_VH
`define CRCU_REGS_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CRCU_OFF_DATA 5'h00
`define CRCU_OFF_SCRATCH 5'h04
`define CRCU_OFF_CTRL 5'h08
`define CRCU_OFF_SEED 5'h10
`define CRCU_OFF_COEFF 5'h14

// ****************************************
// control field positions
// ****************************************
`define CRCU_CTRL_RESTART 0
`define CRCU_CTRL_PWIDTH_LO 3
`define CRCU_CTRL_PWIDTH_HI 4
`define CRCU_CTRL_REVIN_LO 5
`define CRCU_CTRL_REVIN_HI 6
`define CRCU_CTRL_REVOUT 7

// ****************************************
// reset values
// ****************************************
`define CRCU_RST_DATA 32'hFFFFFFFF
`define CRCU_RST_SCRATCH 32'h00000000
`define CRCU_RST_SEED 32'hFFFFFFFF
`define CRCU_RST_COEFF 32'h04C11DB7

// ****************************************
// access sizes and encodings
// ****************************************
`define CRCU_SIZE_BYTE 2'h0
`define CRCU_SIZE_HALF 2'h1
`define CRCU_SIZE_WORD 2'h2
`define CRCU_PW_32 2'h0
`define CRCU_PW_16 2'h1
`define CRCU_PW_8 2'h2
`define CRCU_PW_7 2'h3
`define CRCU_REV_NONE 2'h0
`define CRCU_REV_BYTE 2'h1
`define CRCU_REV_HALF 2'h2
`define CRCU_REV_WORD 2'h3

// ****************************************
// timing: cycles per access size
// ****************************************
`define CRCU_CYC_WORD 3'h4
`define CRCU_CYC_HALF 3'h2
`define CRCU_CYC_BYTE 3'h1

`endif

//--- hw/crcu_fifo.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// input buffer between bus and engine
// ****************************************
module crcu_fifo #(
	parameter WIDTH = 34,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk_sys_in,
	input wire reset_n_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;

	assign in_ready_out = (count != DEPTH[AW:0]);
	assign out_valid_out = (count != {(AW+1){1'b0}});
	assign out_data_out = mem[rd_ptr];
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;

	always @(posedge clk_sys_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	// pointers wrap explicitly so depth need not be a power of two
	always @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			if (push & ~pop) begin
				count <= count + 1'b1;
			end else if (pop & ~push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule // crcu_fifo

`default_nettype wire

//--- hw/crcu_step.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// one byte of polynomial division
// ****************************************
module crcu_step (
	input wire [31:0] crc_in,
	input wire [7:0] byte_in,
	input wire [31:0] coeff_in,
	input wire [4:0] shift_in,
	output reg [31:0] crc_out
);
	reg [31:0] c;
	reg [31:0] p;
	reg fb;
	integer i;

	// narrow checksums are left-aligned so one msb-first loop serves all widths
	always @* begin
		c = crc_in << shift_in;
		p = coeff_in << shift_in;
		fb = 1'b0;
		for (i = 7; i >= 0; i = i - 1) begin
			fb = c[31] ^ byte_in[i];
			c = {c[30:0], 1'b0};
			if (fb) begin
				c = c ^ p;
			end
		end
		crc_out = c >> shift_in;
	end
endmodule // crcu_step

`default_nettype wire

//--- hw/crcu_top.v
`timescale 1ns/1ps
`default_nettype none
`include "crcu_regs.vh"

// Summary of operation
// - data port writes feed the engine a new word instead of storing it
// - data port reads return the checksum of the last completed calculation
// - narrow data and results use the least significant bits of the port
// - seed register is 32-bit read-write, resets to all ones
// - scratch register is plain 32-bit storage, resets to zero
// - restart bit does not touch the scratch register
// - output flip bit returns the checksum bit-reversed on reads
// - input flip field reverses data per byte, half-word or word
// - width field selects 32, 16, 8 or 7 bit generator polynomial
// - writing one to control bit 0 reloads the checksum from seed
// - restart bit is set by software only and self-clears
// - coefficient register is 32-bit read-write, resets to ethernet polynomial
// - all data writes process byte by byte, one byte per cycle
// - word takes 4 cycles, half 2, byte 1; buffer avoids stalls until it is full
// - writing the seed also loads the checksum with it
// - data port allows word, half and byte; others word only
module crcu_top #(
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3
) (
	input wire clk_sys_in,
	input wire reset_n_in,
	input wire reg_sel_in,
	input wire reg_write_in,
	input wire [4:0] reg_addr_in,
	input wire [1:0] reg_size_in,
	input wire [31:0] reg_wdata_in,
	output wire reg_ready_out,
	output reg reg_rvalid_out,
	output reg [31:0] reg_rdata_out,
	output reg reg_error_out,
	output wire busy_out
);
	localparam ENTRY_W = 34;
	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;

	// ****************************************
	// declarations
	// ****************************************
	reg [31:0] checksum_data_port;
	reg [31:0] scratch_word;
	reg [31:0] checksum_seed;
	reg [31:0] generator_coeffs;
	reg [1:0] poly_width_sel;
	reg [1:0] rev_in_sel;
	reg rev_out_en;
	reg restart_pend;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [31:0] shift_data;
	reg [2:0] bytes_left;
	reg [4:0] width_shift;
	reg [31:0] width_mask;
	wire hit_data;
	wire hit_scratch;
	wire hit_ctrl;
	wire hit_seed;
	wire hit_coeff;
	wire addr_ok;
	wire size_ok;
	wire req_err;
	wire need_idle;
	wire engine_idle;
	wire accept;
	wire wr_ok;
	wire rd_ok;
	wire push_valid;
	wire push_ready;
	wire [ENTRY_W-1:0] push_data;
	wire pop_valid;
	wire pop_ready;
	wire [ENTRY_W-1:0] pop_data;
	wire [31:0] entry_aligned;
	wire [7:0] cur_byte;
	wire [31:0] step_crc;
	wire step_en;
	wire [31:0] result_plain;
	wire [31:0] result_read;
	wire [31:0] ctrl_read;
	reg [31:0] masked_wdata;
	reg [31:0] rev_wdata;
	reg [31:0] read_mux;
	reg [1:0] eff_rev;
	integer k;

	// ****************************************
	// helper functions
	// ****************************************
	function [31:0] rev32;
		input [31:0] v;
		integer j;
		begin
			for (j = 0; j < 32; j = j + 1) begin
				rev32[j] = v[31-j];
			end
		end
	endfunction

	// ****************************************
	// address decode
	// ****************************************
	assign hit_data = (reg_addr_in == `CRCU_OFF_DATA);
	assign hit_scratch = (reg_addr_in == `CRCU_OFF_SCRATCH);
	assign hit_ctrl = (reg_addr_in == `CRCU_OFF_CTRL);
	assign hit_seed = (reg_addr_in == `CRCU_OFF_SEED);
	assign hit_coeff = (reg_addr_in == `CRCU_OFF_COEFF);
	assign addr_ok = hit_data | hit_scratch | hit_ctrl | hit_seed | hit_coeff;
	assign size_ok = hit_data ? (reg_size_in != 2'h3) : (reg_size_in == `CRCU_SIZE_WORD);
	assign req_err = ~addr_ok | ~size_ok;

	// reads of the result and changes of seed, polynomial or restart wait for the engine
	// to drain, so a result is never read half-computed and settings never change mid-word
	assign need_idle = ~req_err & ((hit_data & ~reg_write_in) |
		(reg_write_in & (hit_ctrl | hit_seed | hit_coeff)));
	assign engine_idle = (state == ST_IDLE) & ~pop_valid & ~restart_pend;
	assign busy_out = ~engine_idle;

	// buffer takes data writes without waiting for the engine
	assign reg_ready_out = ~reg_sel_in | req_err |
		((hit_data & reg_write_in) ? push_ready : (need_idle ? engine_idle : 1'b1));
	assign accept = reg_sel_in & reg_ready_out;
	assign wr_ok = accept & reg_write_in & ~req_err;
	assign rd_ok = accept & ~reg_write_in & ~req_err;

	// ****************************************
	// input formatting
	// ****************************************
	// narrow data taken from low bits
	always @* begin
		case (reg_size_in)
			`CRCU_SIZE_BYTE: masked_wdata = {24'h000000, reg_wdata_in[7:0]};
			`CRCU_SIZE_HALF: masked_wdata = {16'h0000, reg_wdata_in[15:0]};
			default: masked_wdata = reg_wdata_in;
		endcase
	end

	// reversal group never exceeds the access size, so narrow writes stay right-aligned
	always @* begin
		eff_rev = rev_in_sel;
		if (reg_size_in == `CRCU_SIZE_BYTE && rev_in_sel != `CRCU_REV_NONE) begin
			eff_rev = `CRCU_REV_BYTE;
		end else if (reg_size_in == `CRCU_SIZE_HALF && rev_in_sel == `CRCU_REV_WORD) begin
			eff_rev = `CRCU_REV_HALF;
		end
	end

	always @* begin
		rev_wdata = masked_wdata;
		for (k = 0; k < 32; k = k + 1) begin
			case (eff_rev)
				`CRCU_REV_BYTE: rev_wdata[k] = masked_wdata[(k & ~7) + 7 - (k & 7)];
				`CRCU_REV_HALF: rev_wdata[k] = masked_wdata[(k & ~15) + 15 - (k & 15)];
				`CRCU_REV_WORD: rev_wdata[k] = masked_wdata[31 - k];
				default: rev_wdata[k] = masked_wdata[k];
			endcase
		end
	end

	// data write pushes into the engine
	assign push_valid = reg_sel_in & reg_write_in & hit_data & ~req_err;
	assign push_data = {reg_size_in, rev_wdata};

	crcu_fifo #(
		.WIDTH(ENTRY_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.in_valid_in(push_valid),
		.in_ready_out(push_ready),
		.in_data_in(push_data),
		.out_valid_out(pop_valid),
		.out_ready_in(pop_ready),
		.out_data_out(pop_data)
	);

	// ****************************************
	// polynomial width
	// ****************************************
	// width select
	always @* begin
		case (poly_width_sel)
			`CRCU_PW_16: begin
				width_shift = 5'h10;
				width_mask = 32'h0000FFFF;
			end
			`CRCU_PW_8: begin
				width_shift = 5'h18;
				width_mask = 32'h000000FF;
			end
			`CRCU_PW_7: begin
				width_shift = 5'h19;
				width_mask = 32'h0000007F;
			end
			default: begin
				width_shift = 5'h00;
				width_mask = 32'hFFFFFFFF;
			end
		endcase
	end

	// ****************************************
	// engine
	// ****************************************
	// entries are left-aligned so the next byte is always the top one
	assign entry_aligned = (pop_data[33:32] == `CRCU_SIZE_BYTE) ? {pop_data[7:0], 24'h000000} :
		(pop_data[33:32] == `CRCU_SIZE_HALF) ? {pop_data[15:0], 16'h0000} : pop_data[31:0];
	// first byte is folded in the pop cycle, keeping 4/2/1 cycles per access
	assign pop_ready = (state == ST_IDLE) & ~restart_pend;
	assign step_en = (state == ST_RUN) | (pop_valid & pop_ready);
	assign cur_byte = (state == ST_RUN) ? shift_data[31:24] : entry_aligned[31:24];

	crcu_step u_step (
		.crc_in(checksum_data_port & width_mask),
		.byte_in(cur_byte),
		.coeff_in(generator_coeffs),
		.shift_in(width_shift),
		.crc_out(step_crc)
	);

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (pop_valid & pop_ready & (pop_data[33:32] != `CRCU_SIZE_BYTE)) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (bytes_left == 3'h1) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= ST_IDLE;
			shift_data <= 32'h00000000;
			bytes_left <= 3'h0;
		end else begin
			state <= next_state;
			if (state == ST_RUN) begin
				shift_data <= {shift_data[23:0], 8'h00};
				bytes_left <= bytes_left - 3'h1;
			end else if (pop_valid & pop_ready) begin
				shift_data <= {entry_aligned[23:0], 8'h00};
				case (pop_data[33:32])
					`CRCU_SIZE_WORD: bytes_left <= `CRCU_CYC_WORD - 3'h1;
					`CRCU_SIZE_HALF: bytes_left <= `CRCU_CYC_HALF - 3'h1;
					default: bytes_left <= `CRCU_CYC_BYTE - 3'h1;
				endcase
			end
		end
	end

	// ****************************************
	// checksum register
	// ****************************************
	always @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			checksum_data_port <= `CRCU_RST_DATA;
		end else if (wr_ok & hit_seed) begin
			checksum_data_port <= reg_wdata_in;
		end else if (restart_pend) begin
			checksum_data_port <= checksum_seed;
		end else if (step_en) begin
			checksum_data_port <= step_crc;
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	always @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			scratch_word <= `CRCU_RST_SCRATCH;
			checksum_seed <= `CRCU_RST_SEED;
			generator_coeffs <= `CRCU_RST_COEFF;
			poly_width_sel <= `CRCU_PW_32;
			rev_in_sel <= `CRCU_REV_NONE;
			rev_out_en <= 1'b0;
			restart_pend <= 1'b0;
		end else begin
			if (wr_ok & hit_scratch) begin
				scratch_word <= reg_wdata_in;
			end
			if (wr_ok & hit_seed) begin
				checksum_seed <= reg_wdata_in;
			end
			if (wr_ok & hit_coeff) begin
				generator_coeffs <= reg_wdata_in;
			end
			if (wr_ok & hit_ctrl) begin
				poly_width_sel <= reg_wdata_in[`CRCU_CTRL_PWIDTH_HI:`CRCU_CTRL_PWIDTH_LO];
				rev_in_sel <= reg_wdata_in[`CRCU_CTRL_REVIN_HI:`CRCU_CTRL_REVIN_LO];
				rev_out_en <= reg_wdata_in[`CRCU_CTRL_REVOUT];
			end
			// set by write of one, cleared after one cycle
			if (wr_ok & hit_ctrl & reg_wdata_in[`CRCU_CTRL_RESTART]) begin
				restart_pend <= 1'b1;
			end else if (restart_pend) begin
				restart_pend <= 1'b0;
			end
		end
	end

	// ****************************************
	// read path
	// ****************************************
	// result on low bits
	assign result_plain = checksum_data_port & width_mask;
	// only the read value is flipped
	assign result_read = rev_out_en ? (rev32(result_plain) >> width_shift) : result_plain;
	assign ctrl_read = {24'h000000, rev_out_en, rev_in_sel, poly_width_sel, 2'b00, restart_pend};

	always @* begin
		case (reg_addr_in)
			`CRCU_OFF_DATA: read_mux = result_read;
			`CRCU_OFF_SCRATCH: read_mux = scratch_word;
			`CRCU_OFF_CTRL: read_mux = ctrl_read;
			`CRCU_OFF_SEED: read_mux = checksum_seed;
			`CRCU_OFF_COEFF: read_mux = generator_coeffs;
			default: read_mux = 32'h00000000;
		endcase
	end

	always @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rvalid_out <= 1'b0;
			reg_rdata_out <= 32'h00000000;
			reg_error_out <= 1'b0;
		end else begin
			reg_rvalid_out <= accept;
			reg_error_out <= accept & req_err;
			reg_rdata_out <= rd_ok ? read_mux : 32'h00000000;
		end
	end
endmodule // crcu_top

`default_nettype wire

//--- hw/README_placeholder_none.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- tb/crcu_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checks
// ****************************************
module crcu_properties #(
	parameter FIFO_DEPTH = 8
) (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic reg_sel_in,
	input wire logic reg_write_in,
	input wire logic [4:0] reg_addr_in,
	input wire logic [1:0] reg_size_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_ready_out,
	input wire logic reg_rvalid_out,
	input wire logic [31:0] reg_rdata_out,
	input wire logic reg_error_out,
	input wire logic busy_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	wire logic acc = reg_sel_in && reg_ready_out;
	wire logic a0 = reg_addr_in == 5'h00;
	wire logic hit = a0 || reg_addr_in == 5'h04 || reg_addr_in == 5'h08 || reg_addr_in == 5'h10 || reg_addr_in == 5'h14;
	wire logic bad = reg_size_in == 2'h3 || (!a0 && reg_size_in != 2'h2) || !hit;
	wire logic dsel = reg_sel_in && reg_write_in && a0;
	wire logic dwr = acc && dsel && !busy_out;
	property p_answer; acc |=> reg_rvalid_out; endproperty
	a_answer: assert property (p_answer) else $error("no answer after accept");
	property p_no_extra; reg_rvalid_out |-> $past(acc); endproperty
	a_no_extra: assert property (p_no_extra) else $error("answer without request");
	property p_err; acc && bad |=> reg_error_out && reg_rdata_out == 32'h0; endproperty
	a_err: assert property (p_err) else $error("bad access not flagged");
	property p_ok; acc && !bad |=> !reg_error_out; endproperty
	a_ok: assert property (p_ok) else $error("good access flagged");
	property p_word; dwr && reg_size_in == 2'h2 |=> busy_out [*4]; endproperty
	a_word: assert property (p_word) else $error("word fold shorter than four");
	property p_byte; dwr && reg_size_in == 2'h0 ##1 !dsel |=> !busy_out; endproperty
	a_byte: assert property (p_byte) else $error("byte fold longer than one");
	property p_half; dwr && reg_size_in == 2'h1 ##1 !dsel [*2] |=> !busy_out; endproperty
	a_half: assert property (p_half) else $error("half fold longer than two");
	// an illegal-size read is refused at once as an error, so it is not a stall case
	property p_stall; reg_sel_in && !reg_write_in && a0 && reg_size_in != 2'h3 && busy_out |-> !reg_ready_out;
	endproperty
	a_stall: assert property (p_stall) else $error("data read taken while busy");
	property p_free; reg_sel_in && !reg_write_in && !a0 |-> reg_ready_out; endproperty
	a_free: assert property (p_free) else $error("other read stalled");
	c_word: cover property (dwr && reg_size_in == 2'h2);
	c_bad: cover property (acc && bad);
	c_restart: cover property (acc && reg_write_in && reg_addr_in == 5'h08 && reg_wdata_in[0]);
endmodule // crcu_properties

bind crcu_top crcu_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.clk_sys_in(clk_sys_in),
	.reset_n_in(reset_n_in), .reg_sel_in(reg_sel_in), .reg_write_in(reg_write_in), .reg_addr_in(reg_addr_in),
	.reg_size_in(reg_size_in), .reg_wdata_in(reg_wdata_in), .reg_ready_out(reg_ready_out),
	.reg_rvalid_out(reg_rvalid_out), .reg_rdata_out(reg_rdata_out), .reg_error_out(reg_error_out),
	.busy_out(busy_out));
`default_nettype wire

//--- tb/crcu_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench
// ****************************************
module crcu_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sel = 1'b0;
	logic wr = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [1:0] size = 2'h2;
	logic [31:0] wd = 32'h0;
	wire logic rdy, rv, er, bsy;
	wire logic [31:0] rd;
	int fail_count = 0;
	int check_count = 0;
	logic [31:0] q, crc, ctl, co, sd, sc, d;
	logic e;
	logic [1:0] s;

	crcu_top #(.FIFO_DEPTH(8), .FIFO_AW(3)) uut (.clk_sys_in(clk), .reset_n_in(rst_n), .reg_sel_in(sel),
		.reg_write_in(wr), .reg_addr_in(addr), .reg_size_in(size), .reg_wdata_in(wd), .reg_ready_out(rdy),
		.reg_rvalid_out(rv), .reg_rdata_out(rd), .reg_error_out(er), .busy_out(bsy));

	always #4 clk = ~clk;

	function automatic int wof(input logic [31:0] k);
		return k[4:3] == 2'h0 ? 32 : k[4:3] == 2'h1 ? 16 : k[4:3] == 2'h2 ? 8 : 7;
	endfunction

	function automatic logic [31:0] flip(input logic [31:0] v, input int n);
		logic [31:0] r;
		r = 32'h0;
		for (int i = 0; i < n; i++) r[n - 1 - i] = v[i];
		return r;
	endfunction

	// msb-first division; input reversal group capped by access size
	function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] x, input logic [1:0] z);
		int w, nb, g;
		logic [31:0] m, y;
		logic fb;
		w = wof(ctl);
		nb = 8 << z;
		g = ctl[6:5] == 2'h0 ? 1 : 8 << (ctl[6:5] - 1);
		if (g > nb) g = nb;
		m = w == 32 ? 32'hFFFFFFFF : (32'h1 << w) - 1;
		y = 32'h0;
		for (int i = 0; i < nb; i++) y[i - i % g + g - 1 - i % g] = x[i];
		for (int i = nb - 1; i >= 0; i--) begin
			fb = c[w - 1] ^ y[i];
			c = (c << 1) & m;
			if (fb) c = c ^ (co & m);
		end
		return c;
	endfunction

	function automatic logic [31:0] view(input logic [31:0] c);
		return ctl[7] ? flip(c, wof(ctl)) : c;
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask

	// hold the request until the edge that takes it
	task automatic drive(input logic w, input logic [4:0] a, input logic [1:0] z, input logic [31:0] v);
		int n;
		n = 0;
		sel <= 1'b1;
		wr <= w;
		addr <= a;
		size <= z;
		wd <= v;
		@(negedge clk);
		while (rdy !== 1'b1 && n < 300) begin
			n++;
			@(negedge clk);
		end
		if (n == 300) begin
			fail_count++;
			stop_test();
		end
		@(posedge clk);
	endtask

	task automatic acc(input logic w, input logic [4:0] a, input logic [1:0] z, input logic [31:0] v);
		@(posedge clk);
		drive(w, a, z, v);
		sel <= 1'b0;
		@(negedge clk);
		q = rd;
		e = er;
		chk({31'h0, rv}, 32'h1);
	endtask

	initial begin
		void'($urandom(32'haeae));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		acc(0, 5'h00, 2, 0); chk(q, 32'hFFFFFFFF);
		acc(0, 5'h04, 2, 0); chk(q, 32'h00000000);
		acc(0, 5'h08, 2, 0); chk(q, 32'h00000000);
		acc(0, 5'h10, 2, 0); chk(q, 32'hFFFFFFFF);
		acc(0, 5'h14, 2, 0); chk(q, 32'h04C11DB7);
		$display("test 1 done");
		acc(1, 5'h0C, 2, $urandom); chk({31'h0, e}, 32'h1);
		acc(0, 5'h18, 2, 0); chk({31'h0, e}, 32'h1);
		acc(1, 5'h00, 3, $urandom); chk({31'h0, e}, 32'h1);
		acc(0, 5'h04, 0, 0); chk({31'h0, e} | q, 32'h1);
		sd = $urandom;
		acc(1, 5'h10, 2, sd);
		acc(0, 5'h00, 2, 0); chk(q, sd);
		$display("test 2 done");
		for (int t = 0; t < 30; t++) begin
			ctl = ($urandom & 32'h80) | {t[3:0], 3'h0};
			co = ($urandom & (wof(ctl) == 32 ? 32'hFFFFFFFF : (32'h1 << wof(ctl)) - 32'h1)) | 32'h1;
			sd = $urandom;
			sc = $urandom;
			acc(1, 5'h04, 2, sc);
			acc(1, 5'h14, 2, co);
			acc(0, 5'h14, 2, 0); chk(q, co);
			acc(1, 5'h10, 2, sd);
			acc(0, 5'h10, 2, 0); chk(q, sd);
			acc(1, 5'h00, 2, $urandom);
			acc(1, 5'h08, 2, ctl | 32'h1);
			crc = sd;
			acc(0, 5'h08, 2, 0); chk(q, ctl);
			repeat ($urandom_range(1, 4)) begin
				s = $urandom_range(0, 2);
				d = $urandom;
				if (s != 2'h2) d = d & ~(32'hFFFFFFFF << (8 << s));
				acc(1, 5'h00, s, d);
				crc = crc_ref(crc, d, s);
			end
			acc(0, 5'h00, 2, 0); chk(q, view(crc));
			ctl[7] = ~ctl[7];
			acc(1, 5'h08, 2, ctl);
			acc(0, 5'h00, 2, 0); chk(q, view(crc));
			acc(0, 5'h04, 2, 0); chk(q, sc);
		end
		$display("test 3 done");
		acc(1, 5'h08, 2, ctl | 32'h1);
		crc = sd;
		@(posedge clk);
		for (int i = 0; i < 12; i++) begin
			d = $urandom;
			crc = crc_ref(crc, d, 2);
			drive(1, 5'h00, 2, d);
		end
		sel <= 1'b0;
		@(negedge clk);
		chk({31'h0, bsy}, 32'h1);
		acc(0, 5'h00, 2, 0); chk(q, view(crc));
		$display("test 4 done");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		acc(0, 5'h04, 2, 0); chk(q, 32'h00000000);
		acc(0, 5'h10, 2, 0); chk(q, 32'hFFFFFFFF);
		acc(0, 5'h14, 2, 0); chk(q, 32'h04C11DB7);
		acc(0, 5'h00, 2, 0); chk(q, 32'hFFFFFFFF);
		$display("test 5 done");
		stop_test();
	end
endmodule // crcu_tb_top
`default_nettype wire
